//--- include/dcs_pkg.sv
// Constants and types shared by the dual oscillator clock select block
package dcs_pkg;

	// Register port geometry
	localparam int unsigned DCS_ADDR_W = 4;
	localparam int unsigned DCS_DATA_W = 4;

	// Register indices
	localparam logic [3:0] DCS_FREQ_CTRL_ADDR = 4'h0;
	localparam logic [3:0] DCS_STATUS_ADDR    = 4'h1;

	// Frequency control register fields
	localparam int unsigned DCS_CORE_SEL_BIT  = 0;
	localparam int unsigned DCS_RUN_BIT       = 1;
	localparam int unsigned DCS_TYPE_SEL_BIT  = 2;

	// Status register fields
	localparam int unsigned DCS_ST_ON_FAST_BIT   = 0;
	localparam int unsigned DCS_ST_SWITCHING_BIT = 1;
	localparam int unsigned DCS_ST_FAST_ALIVE_BIT = 2;
	localparam int unsigned DCS_ST_SLOW_ALIVE_BIT = 3;

	// Values after reset
	localparam logic [3:0] DCS_FREQ_CTRL_RESET = 4'h0;
	localparam logic [3:0] DCS_READ_RESET      = 4'h0;

	// Oscillator activity watchdog, in system clock cycles
	localparam int unsigned DCS_ALIVE_W       = 8;
	localparam logic [7:0]  DCS_ALIVE_TIMEOUT = 8'hFF;

	// Clock multiplexer states, Gray coded around the loop
	typedef enum logic [1:0] {
		DCS_ON_SLOW      = 2'b00,
		DCS_PARK_TO_FAST = 2'b01,
		DCS_ON_FAST      = 2'b11,
		DCS_PARK_TO_SLOW = 2'b10
	} dcs_mux_state_t;

endpackage

//--- design/dcs_fast_divider.sv
// High-speed clock former: pass-through or divide by two of the source
`timescale 1ns/10ps
module dcs_fast_divider
	import dcs_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	// Control
	input  wire logic fast_osc_run_i,
	input  wire logic fast_osc_type_select_i,
	// Source oscillation and result
	input  wire logic fast_src_i,
	output logic      fast_clock_o
);

	logic src_q;
	logic src_prev;
	logic half;
	logic next_half;
	logic next_fast;
	wire  src_rise = src_q & ~src_prev;

	// Halver held at zero while stopped, so it restarts low
	assign next_half = fast_osc_run_i ? (half ^ src_rise) : 1'b0;
	// Crystal mode halves the source, RC mode passes it
	assign next_fast = ~fast_osc_run_i ? 1'b0 :
		(fast_osc_type_select_i ? half : src_q);

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			src_q        <= 1'b0;
			src_prev     <= 1'b0;
			half         <= 1'b0;
			fast_clock_o <= 1'b0;
		end
		else
		begin
			src_q        <= fast_src_i;
			src_prev     <= src_q;
			half         <= next_half;
			fast_clock_o <= next_fast;
		end
	end

endmodule

//--- design/dcs_clock_select.sv
// Clock controller: control register, fast clock former, glitch-free mux
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps

// How it works
// - Core clock select 0 picks timebase clock, 1 picks fast clock.
// - Reset clears core clock select, so timebase clock drives the core.
// - Type select 0 means RC oscillation, 1 means crystal oscillation.
// - RC mode passes the source undivided; at most 2.048 MHz.
// - Crystal mode halves the source; source at most 4.096 MHz.
// - Low-speed oscillator keeps running and timebase clock stays available.
// - Timebase clock drives the time base counter regardless of selection.
// - Low-speed oscillator mode is a build-time parameter, not software.
// - Run bit starts or stops fast oscillator; reset clears run and type.
module dcs_clock_select
	import dcs_pkg::*;
#(
	// 1 = crystal, 0 = RC for the low-speed oscillator
	parameter bit SLOW_OSC_CRYSTAL = 1'b1
)
(
	// Clock and reset
	input  wire logic                  sys_clk_i,
	input  wire logic                  reset_i,
	// Register port
	input  wire logic [DCS_ADDR_W-1:0] reg_addr_i,
	input  wire logic [DCS_DATA_W-1:0] reg_wdata_i,
	input  wire logic                  reg_write_i,
	input  wire logic                  reg_read_i,
	output logic      [DCS_DATA_W-1:0] reg_rdata_o,
	// Oscillator sources
	input  wire logic                  slow_src_i,
	input  wire logic                  fast_src_i,
	// Oscillator controls
	output logic                       slow_osc_run_o,
	output logic                       slow_osc_crystal_mode_o,
	output logic                       fast_osc_run_o,
	output logic                       fast_osc_type_select_o,
	// Clock outputs
	output logic                       timebase_clock_o,
	output logic                       fast_clock_o,
	output logic                       sys_clock_o
);

	// Control register bits
	logic core_clock_select;
	logic fast_osc_run;
	logic fast_osc_type_select;

	// Source samples
	logic slow_q;
	logic slow_prev;
	logic fast_prev;
	logic fast_clock;

	// Activity watchdogs
	logic [DCS_ALIVE_W-1:0] slow_idle;
	logic [DCS_ALIVE_W-1:0] fast_idle;
	logic [DCS_ALIVE_W-1:0] next_slow_idle;
	logic [DCS_ALIVE_W-1:0] next_fast_idle;

	// Multiplexer
	dcs_mux_state_t mux_state;
	dcs_mux_state_t next_mux_state;
	logic           next_sys_clock;

	// Read path
	logic [DCS_DATA_W-1:0] next_rdata;

	// Idle counter saturates at the timeout
	function automatic logic [DCS_ALIVE_W-1:0] idle_step(
		input logic                   edge_seen,
		input logic [DCS_ALIVE_W-1:0] count
	);
		if (edge_seen)
			idle_step = '0;
		else if (count == DCS_ALIVE_TIMEOUT)
			idle_step = count;
		else
			idle_step = count + 1'b1;
	endfunction

	// Register decode
	wire ctrl_hit   = reg_addr_i == DCS_FREQ_CTRL_ADDR;
	wire status_hit = reg_addr_i == DCS_STATUS_ADDR;
	wire ctrl_write = reg_write_i & ctrl_hit;

	// Oscillator health
	wire slow_edge  = slow_q ^ slow_prev;
	wire fast_edge  = fast_clock ^ fast_prev;
	wire slow_alive = slow_idle != DCS_ALIVE_TIMEOUT;
	wire fast_alive = fast_osc_run & (fast_idle != DCS_ALIVE_TIMEOUT);

	assign next_slow_idle = idle_step(slow_edge, slow_idle);
	assign next_fast_idle = idle_step(fast_edge, fast_idle);

	// Views of the registers
	wire [DCS_DATA_W-1:0] ctrl_view = {1'b0, fast_osc_type_select,
		fast_osc_run, core_clock_select};
	wire switching = (mux_state == DCS_PARK_TO_FAST) |
		(mux_state == DCS_PARK_TO_SLOW);
	wire [DCS_DATA_W-1:0] status_view = {slow_alive, fast_alive,
		switching, mux_state == DCS_ON_FAST};

	// Unmapped reads answer zero
	assign next_rdata = !reg_read_i ? DCS_READ_RESET :
		(ctrl_hit ? ctrl_view :
		(status_hit ? status_view : DCS_READ_RESET));

	// Low-speed oscillator never stopped by this block
	assign slow_osc_run_o          = 1'b1;
	assign slow_osc_crystal_mode_o = SLOW_OSC_CRYSTAL;
	assign fast_osc_run_o          = fast_osc_run;
	assign fast_osc_type_select_o  = fast_osc_type_select;
	assign fast_clock_o            = fast_clock;

	dcs_fast_divider u_fast_divider
	(
		.sys_clk_i              (sys_clk_i),
		.reset_i                (reset_i),
		.fast_osc_run_i         (fast_osc_run),
		.fast_osc_type_select_i (fast_osc_type_select),
		.fast_src_i             (fast_src_i),
		.fast_clock_o           (fast_clock)
	);

	// Switch only while the old clock is low, park low, then join the new
	// clock while it is low, so no shortened high phase reaches the core.
	always_comb
	begin
		next_mux_state = mux_state;
		unique case (mux_state)
			DCS_ON_SLOW:
				if (core_clock_select && !slow_q)
					next_mux_state = DCS_PARK_TO_FAST;
			DCS_PARK_TO_FAST:
				if (!core_clock_select)
					next_mux_state = DCS_PARK_TO_SLOW;
				else if (!fast_clock)
					next_mux_state = DCS_ON_FAST;
			DCS_ON_FAST:
				if (!core_clock_select && !fast_clock)
					next_mux_state = DCS_PARK_TO_SLOW;
			DCS_PARK_TO_SLOW:
				if (core_clock_select)
					next_mux_state = DCS_PARK_TO_FAST;
				else if (!slow_q)
					next_mux_state = DCS_ON_SLOW;
		endcase
	end

	// Output follows the source of the state being entered
	always_comb
	begin
		next_sys_clock = 1'b0;
		unique case (next_mux_state)
			DCS_ON_SLOW:      next_sys_clock = slow_q;
			DCS_ON_FAST:      next_sys_clock = fast_clock;
			DCS_PARK_TO_FAST: next_sys_clock = 1'b0;
			DCS_PARK_TO_SLOW: next_sys_clock = 1'b0;
		endcase
	end

	// Control register
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			core_clock_select    <= DCS_FREQ_CTRL_RESET[DCS_CORE_SEL_BIT];
			fast_osc_run         <= DCS_FREQ_CTRL_RESET[DCS_RUN_BIT];
			fast_osc_type_select <= DCS_FREQ_CTRL_RESET[DCS_TYPE_SEL_BIT];
		end
		else if (ctrl_write)
		begin
			core_clock_select    <= reg_wdata_i[DCS_CORE_SEL_BIT];
			fast_osc_run         <= reg_wdata_i[DCS_RUN_BIT];
			fast_osc_type_select <= reg_wdata_i[DCS_TYPE_SEL_BIT];
		end
	end

	// Timebase clock runs whatever the core selection
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			slow_q           <= 1'b0;
			slow_prev        <= 1'b0;
			timebase_clock_o <= 1'b0;
		end
		else
		begin
			slow_q           <= slow_src_i;
			slow_prev        <= slow_q;
			timebase_clock_o <= slow_q;
		end
	end

	// Watchdogs
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			fast_prev <= 1'b0;
			slow_idle <= DCS_ALIVE_TIMEOUT;
			fast_idle <= DCS_ALIVE_TIMEOUT;
		end
		else
		begin
			fast_prev <= fast_clock;
			slow_idle <= next_slow_idle;
			fast_idle <= next_fast_idle;
		end
	end

	// Multiplexer and read data
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			mux_state   <= DCS_ON_SLOW;
			sys_clock_o <= 1'b0;
			reg_rdata_o <= DCS_READ_RESET;
		end
		else
		begin
			mux_state   <= next_mux_state;
			sys_clock_o <= next_sys_clock;
			reg_rdata_o <= next_rdata;
		end
	end

endmodule

//--- verification/dcs_clock_select_props.sv
// Port checker for the clock select block
`timescale 1ns/10ps
module dcs_clock_select_props
	import dcs_pkg::*;
#(
	parameter bit SLOW_OSC_CRYSTAL = 1'b1
)
(
	// Clock, reset, register port
	input wire logic                  sys_clk_i,
	input wire logic                  reset_i,
	input wire logic [DCS_ADDR_W-1:0] reg_addr_i,
	input wire logic [DCS_DATA_W-1:0] reg_wdata_i,
	input wire logic                  reg_write_i,
	input wire logic                  reg_read_i,
	input wire logic [DCS_DATA_W-1:0] reg_rdata_o,
	// Oscillators and clocks
	input wire logic                  slow_src_i,
	input wire logic                  fast_src_i,
	input wire logic                  slow_osc_run_o,
	input wire logic                  slow_osc_crystal_mode_o,
	input wire logic                  fast_osc_run_o,
	input wire logic                  fast_osc_type_select_o,
	input wire logic                  timebase_clock_o,
	input wire logic                  fast_clock_o,
	input wire logic                  sys_clock_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	wire ctl_wr = reg_write_i && reg_addr_i == DCS_FREQ_CTRL_ADDR;
	tb_lag_a: assert property (
		!$past(reset_i) && !$past(reset_i, 2)
		|-> timebase_clock_o == $past(slow_src_i, 2)) else $error("timebase lag");
	rc_pass_a: assert property (
		$past(fast_osc_run_o) && !$past(fast_osc_type_select_o)
		|-> fast_clock_o == $past(fast_src_i, 2)) else $error("rc pass");
	stop_low_a: assert property (
		!fast_osc_run_o && !$past(fast_osc_run_o) && !$past(fast_osc_run_o, 2)
		|-> !fast_clock_o) else $error("stopped fast clock");
	ctl_reset_a: assert property (
		$fell(reset_i) |-> !fast_osc_run_o && !fast_osc_type_select_o)
		else $error("control reset");
	slow_fixed_a: assert property (
		slow_osc_run_o && slow_osc_crystal_mode_o == SLOW_OSC_CRYSTAL)
		else $error("slow osc config");
	ctl_write_a: assert property (
		ctl_wr |=> fast_osc_run_o == $past(reg_wdata_i[1])
		&& fast_osc_type_select_o == $past(reg_wdata_i[2])) else $error("ctl write");
	// Slow path is level with the timebase output, fast path one edge late
	sys_source_a: assert property (
		sys_clock_o |-> timebase_clock_o || $past(fast_clock_o))
		else $error("sys source");
	no_runt_a: assert property (
		sys_clock_o != $past(sys_clock_o) |=> $stable(sys_clock_o))
		else $error("sys runt");
	ctl_read_a: assert property (
		reg_read_i && reg_addr_i == DCS_FREQ_CTRL_ADDR
		|=> reg_rdata_o[3:1] == {1'b0, fast_osc_type_select_o, fast_osc_run_o})
		else $error("ctl read");
	cover property (ctl_wr && reg_wdata_i[0]);
	cover property ($rose(fast_clock_o) && fast_osc_type_select_o);
	cover property ($rose(sys_clock_o) && fast_osc_run_o);
endmodule

//--- verification/dcs_osc_model.sv
// Oscillator model driving both source inputs
`timescale 1ns/10ps
module dcs_osc_model
#(
	parameter int SLOW_HALF = 10,
	parameter int FAST_HALF = 3
)
(
	// Clock, reset, control
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	input  wire logic fast_osc_run_i,
	// Sources
	output logic      slow_src_o,
	output logic      fast_src_o
);
	int sc;
	int fc;
	always @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			{sc, fc, slow_src_o, fast_src_o} <= '0;
		end
		else
		begin
			sc <= (sc == SLOW_HALF - 1) ? 0 : sc + 1;
			slow_src_o <= slow_src_o ^ (sc == SLOW_HALF - 1);
			// A stopped oscillator rests low
			fc <= (!fast_osc_run_i || fc == FAST_HALF - 1) ? 0 : fc + 1;
			fast_src_o <= fast_osc_run_i && (fast_src_o ^ (fc == FAST_HALF - 1));
		end
	end
endmodule

//--- verification/dcs_clock_select_test.sv
// Self-checking bench for the clock select block
`timescale 1ns/10ps
module dcs_clock_select_test;
	import dcs_pkg::*;
	logic       sys_clk_i, reset_i, reg_write_i, reg_read_i;
	logic [3:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [3:0] prv = 4'h0;
	logic       slow_src_i, fast_src_i, slow_run, slow_xtal, run, typ;
	logic       timebase_clock_o, fast_clock_o, sys_clock_o;
	int         fails = 0, n_checks = 0, s, f, t, y;
	int         n_src = 0, n_fc = 0, n_tb = 0, n_sys = 0;
	dcs_clock_select dcs_clock_select_i (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
		.reg_rdata_o(reg_rdata_o), .slow_src_i(slow_src_i),
		.fast_src_i(fast_src_i), .slow_osc_run_o(slow_run),
		.slow_osc_crystal_mode_o(slow_xtal), .fast_osc_run_o(run),
		.fast_osc_type_select_o(typ), .timebase_clock_o(timebase_clock_o),
		.fast_clock_o(fast_clock_o), .sys_clock_o(sys_clock_o));
	dcs_osc_model dcs_osc_model_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.fast_osc_run_i(run), .slow_src_o(slow_src_i), .fast_src_o(fast_src_i));
	always @(posedge sys_clk_i)
	begin
		n_src <= n_src + int'(fast_src_i && !prv[0]);
		n_fc <= n_fc + int'(fast_clock_o && !prv[1]);
		n_tb <= n_tb + int'(timebase_clock_o && !prv[2]);
		n_sys <= n_sys + int'(sys_clock_o && !prv[3]);
		prv <= {sys_clock_o, timebase_clock_o, fast_clock_o, fast_src_i};
	end
	task automatic chk_v(input string nm, input logic [3:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_n(input string nm, input int e, g);
		n_checks++;
		if (g < e - 1 || g > e + 1)
		begin
			fails++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_write_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_write_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, e);
		reg_addr_i <= a;
		reg_read_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_read_i <= 1'b0;
		#1 chk_v("rdata", e, reg_rdata_o);
		@(posedge sys_clk_i);
	endtask
	// Edge counts over a window; boundaries cost at most one edge
	task automatic meas(input int n);
		{s, f, t, y} = {n_src, n_fc, n_tb, n_sys};
		repeat (n) @(posedge sys_clk_i);
		{s, f, t, y} = {n_src - s, n_fc - f, n_tb - t, n_sys - y};
	endtask
	task t_reset;
		rd(DCS_FREQ_CTRL_ADDR, 4'h0);
		meas(200);
		chk_n("sys", 10, y);
		chk_n("fast", 0, f);
		rd(DCS_STATUS_ADDR, 4'h8);
		rd(4'h5, 4'h0);
		chk_v("slow osc", 4'h3, {2'h0, slow_run, slow_xtal});
		$display("reset test done");
	endtask
	// Software waits are scaled down to the model's quick start
	task t_rc;
		wr(DCS_FREQ_CTRL_ADDR, 4'h2);
		repeat (50) @(posedge sys_clk_i);
		meas(120);
		chk_n("rc fast", s, f);
		wr(DCS_FREQ_CTRL_ADDR, 4'h3);
		repeat (40) @(posedge sys_clk_i);
		rd(DCS_STATUS_ADDR, 4'hD);
		meas(120);
		chk_n("sys fast", s, y);
		chk_n("timebase", 6, t);
		wr(DCS_FREQ_CTRL_ADDR, 4'h2);
		@(posedge sys_clk_i);
		wr(DCS_FREQ_CTRL_ADDR, 4'h0);
		repeat (40) @(posedge sys_clk_i);
		rd(DCS_STATUS_ADDR, 4'h8);
		$display("rc test done");
	endtask
	task t_xtal;
		wr(DCS_FREQ_CTRL_ADDR, 4'h6);
		repeat (50) @(posedge sys_clk_i);
		rd(DCS_FREQ_CTRL_ADDR, 4'h6);
		meas(120);
		chk_n("xtal fast", s / 2, f);
		wr(DCS_FREQ_CTRL_ADDR, 4'h0);
		repeat (4) @(posedge sys_clk_i);
		meas(60);
		chk_n("stopped", 0, f);
		chk_v("fast level", 4'h0, {3'h0, fast_clock_o});
		$display("crystal test done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	initial
	begin
		#200000;
		fails++;
		close_out;
	end
	initial
	begin
		{reset_i, reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i} = 11'h400;
		repeat (10) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		t_reset;
		t_rc;
		t_xtal;
		close_out;
	end
endmodule
bind dcs_clock_select dcs_clock_select_props #(
	.SLOW_OSC_CRYSTAL(SLOW_OSC_CRYSTAL)) dcs_clock_select_props_i (.*);
